// ---- test/fbis_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module fbis_assertions
    import fbis_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              obj_req,
    input wire logic              obj_wr,
    input wire logic [IDX_W-1:0]  obj_index,
    input wire logic [SUB_W-1:0]  obj_subindex,
    input wire logic              obj_ack,
    input wire logic              obj_abort,
    input wire logic [DATA_W-1:0] obj_rdata,
    input wire logic              save_req,
    input wire logic              nv_save_stb,
    input wire logic [DATA_W-1:0] bus_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence ctrl_wr;
        obj_req && obj_wr && obj_index == IDX_CONTROL
            && obj_subindex == SUB_VALUE;
    endsequence
    sequence cnt_rd;
        obj_req && !obj_wr && obj_index == IDX_STATUS
            && obj_subindex == SUB_ENTRY_COUNT;
    endsequence

    ack_latency_a: assert property (obj_req |=> obj_ack)
        else $error("no answer one cycle after request");
    ack_cause_a: assert property (obj_ack |-> $past(obj_req))
        else $error("answer without request");
    ro_write_a: assert property (obj_req && obj_wr && obj_index != IDX_CONTROL
        |=> obj_abort)
        else $error("write to read-only object accepted");
    ctrl_write_a: assert property (ctrl_wr |=> obj_ack && !obj_abort)
        else $error("control write refused");
    count_read_a: assert property (cnt_rd |=> obj_rdata == 32'h0000_0002)
        else $error("entry count wrong");
    abort_zero_a: assert property (obj_abort |-> obj_rdata == '0)
        else $error("abort with data");
    unused_read_a: assert property (obj_ack |-> !(|(obj_rdata & ~ASSIGNED_MASK)))
        else $error("unassigned bit read as one");
    unused_en_a: assert property (!(|(bus_enable & ~ASSIGNED_MASK)))
        else $error("unassigned enable set");
    save_stb_a: assert property (save_req |=> nv_save_stb)
        else $error("no save strobe");
    stb_cause_a: assert property (nv_save_stb |-> $past(save_req))
        else $error("save strobe without request");
endmodule
bind fbis_top fbis_assertions u_chk (
    .clk          (clk),
    .srst         (srst),
    .obj_req      (obj_req),
    .obj_wr       (obj_wr),
    .obj_index    (obj_index),
    .obj_subindex (obj_subindex),
    .obj_ack      (obj_ack),
    .obj_abort    (obj_abort),
    .obj_rdata    (obj_rdata),
    .save_req     (save_req),
    .nv_save_stb  (nv_save_stb),
    .bus_enable   (bus_enable)
);
`default_nettype wire

// ---- test/tb_fieldbus_interface_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_fieldbus_interface_select
    import fbis_pkg::*;
;
    logic              clk = 1'b0;
    logic              srst, obj_req, obj_wr, obj_ack, obj_abort, ab;
    logic              save_req, nv_save_stb, nv_restore_valid;
    logic [IDX_W-1:0]  obj_index;
    logic [SUB_W-1:0]  obj_subindex;
    logic [DATA_W-1:0] obj_wdata, obj_rdata, hw_available, hw_switchable;
    logic [DATA_W-1:0] nv_save_data, nv_restore_data, bus_enable, rd;
    int                n_mismatch = 0;
    int                n_compared = 0;
    int                bits [10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18};

    fbis_top u_dut (
        .clk              (clk),
        .srst             (srst),
        .obj_req          (obj_req),
        .obj_wr           (obj_wr),
        .obj_index        (obj_index),
        .obj_subindex     (obj_subindex),
        .obj_wdata        (obj_wdata),
        .obj_ack          (obj_ack),
        .obj_abort        (obj_abort),
        .obj_rdata        (obj_rdata),
        .hw_available     (hw_available),
        .hw_switchable    (hw_switchable),
        .save_req         (save_req),
        .nv_save_stb      (nv_save_stb),
        .nv_save_data     (nv_save_data),
        .nv_restore_valid (nv_restore_valid),
        .nv_restore_data  (nv_restore_data),
        .bus_enable       (bus_enable)
    );
    always #2 clk = ~clk;

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [IDX_W-1:0] i,
                       input logic [SUB_W-1:0] s, input logic [DATA_W-1:0] d);
        @(posedge clk);
        obj_req <= 1'b1;
        obj_wr <= w;
        obj_index <= i;
        obj_subindex <= s;
        obj_wdata <= d;
        @(posedge clk);
        obj_req <= 1'b0;
        #1;
        chk(DATA_W'(obj_ack), 32'h0000_0001);
        rd = obj_rdata;
        ab = obj_abort;
    endtask
    task automatic rdc(input logic [IDX_W-1:0] i, input logic [SUB_W-1:0] s,
                       input logic [DATA_W-1:0] e, input logic eab);
        acc(1'b0, i, s, 32'h0);
        chk(rd, e);
        chk(DATA_W'(ab), DATA_W'(eab));
    endtask
    task automatic wrc(input logic [IDX_W-1:0] i, input logic [SUB_W-1:0] s,
                       input logic [DATA_W-1:0] d, input logic eab);
        acc(1'b1, i, s, d);
        chk(DATA_W'(ab), DATA_W'(eab));
    endtask

    task automatic t_reset;
        rdc(IDX_AVAILABILITY, SUB_VALUE, 32'h0000_0008, 1'b0);
        chk(bus_enable, 32'h0000_0008);
        chk(nv_save_data, 32'h0000_0008);
        rdc(IDX_CONTROL, SUB_VALUE, 32'h0000_0008, 1'b0);
        rdc(IDX_STATUS, SUB_ENTRY_COUNT, 32'h0000_0002, 1'b0);
        rdc(IDX_STATUS, SUB_SWITCHABLE, 32'h0000_0000, 1'b0);
        rdc(IDX_STATUS, SUB_ACTIVE, 32'h0000_0008, 1'b0);
        rdc(16'h2104, SUB_VALUE, 32'h0000_0000, 1'b1);
        rdc(IDX_STATUS, 8'h03, 32'h0000_0000, 1'b1);
    endtask
    // Nothing switchable yet, so every control write must be ignored
    task automatic t_locked;
        wrc(IDX_CONTROL, SUB_VALUE, 32'h0007_0070, 1'b0);
        rdc(IDX_CONTROL, SUB_VALUE, 32'h0000_0008, 1'b0);
        wrc(IDX_AVAILABILITY, SUB_VALUE, 32'h0000_0000, 1'b1);
        wrc(IDX_STATUS, SUB_SWITCHABLE, 32'hFFFF_FFFF, 1'b1);
        wrc(IDX_STATUS, SUB_ACTIVE, 32'h0000_0000, 1'b1);
        rdc(IDX_STATUS, SUB_ACTIVE, 32'h0000_0008, 1'b0);
    endtask
    task automatic t_switch;
        @(posedge clk);
        hw_available <= 32'hFFFF_FFFF;
        hw_switchable <= 32'hFFFF_FFFF;
        repeat (2) @(posedge clk);
        rdc(IDX_STATUS, SUB_SWITCHABLE, 32'h0007_007F, 1'b0);
        rdc(IDX_AVAILABILITY, SUB_VALUE, 32'h0007_007F, 1'b0);
        foreach (bits[k])
        begin
            wrc(IDX_CONTROL, SUB_VALUE, 32'h1 << bits[k], 1'b0);
            rdc(IDX_STATUS, SUB_ACTIVE, 32'h1 << bits[k], 1'b0);
            chk(bus_enable, 32'h1 << bits[k]);
        end
        wrc(IDX_CONTROL, SUB_VALUE, 32'hFFFF_FFFF, 1'b0);
        rdc(IDX_CONTROL, SUB_VALUE, 32'h0007_007F, 1'b0);
        @(posedge clk);
        hw_switchable <= 32'h0000_0010;
        repeat (2) @(posedge clk);
        wrc(IDX_CONTROL, SUB_VALUE, 32'h0000_0000, 1'b0);
        rdc(IDX_STATUS, SUB_ACTIVE, 32'h0007_006F, 1'b0);
    endtask
    task automatic t_save;
        @(posedge clk);
        save_req <= 1'b1;
        @(posedge clk);
        save_req <= 1'b0;
        #1;
        chk(DATA_W'(nv_save_stb), 32'h0000_0001);
        chk(nv_save_data, 32'h0007_006F);
        @(posedge clk);
        nv_restore_valid <= 1'b1;
        nv_restore_data <= 32'h0000_0010;
        @(posedge clk);
        nv_restore_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(IDX_CONTROL, SUB_VALUE, 32'h0007_007F, 1'b0);
    endtask

    initial
    begin
        {obj_req, obj_wr, save_req, nv_restore_valid} = '0;
        {obj_index, obj_subindex, obj_wdata, nv_restore_data} = '0;
        srst = 1'b1;
        hw_available = 32'h0000_0008;
        hw_switchable = 32'h0000_0000;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_locked;
        t_switch;
        t_save;
        stop_test;
    end
    // Whole sequence needs about 100 cycles
    initial
    begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule
`default_nettype wire

// ---- verilog/fbis_persist.sv ----
`timescale 1ns/10ps
`default_nettype none
module fbis_persist
    import fbis_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              save_req,
    input  wire logic [DATA_W-1:0] ctrl_value,
    input  wire logic              nv_restore_valid,
    input  wire logic [DATA_W-1:0] nv_restore_data,
    output logic                   nv_save_stb,
    output logic       [DATA_W-1:0] nv_save_data,
    output logic                   restore_stb,
    output logic       [DATA_W-1:0] restore_value
);
    // Image lives outside; this end only frames the save and restore
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nv_save_stb  <= 1'b0;
            nv_save_data <= CONTROL_RST;
        end
        else
        begin
            nv_save_stb <= save_req;
            if (save_req)
            begin
                nv_save_data <= ctrl_value & ASSIGNED_MASK;
            end
        end
    end

    // Restored image is applied only after reset has been released
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            restore_stb   <= 1'b0;
            restore_value <= CONTROL_RST;
        end
        else
        begin
            restore_stb <= nv_restore_valid;
            if (nv_restore_valid)
            begin
                restore_value <= nv_restore_data & ASSIGNED_MASK;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/fbis_pkg.sv ----
`default_nettype none
package fbis_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 16;
    localparam int unsigned SUB_W  = 8;

    localparam logic [IDX_W-1:0] IDX_AVAILABILITY = 16'h2101;
    localparam logic [IDX_W-1:0] IDX_CONTROL      = 16'h2102;
    localparam logic [IDX_W-1:0] IDX_STATUS       = 16'h2103;

    localparam logic [SUB_W-1:0] SUB_VALUE        = 8'h00;
    localparam logic [SUB_W-1:0] SUB_ENTRY_COUNT  = 8'h00;
    localparam logic [SUB_W-1:0] SUB_SWITCHABLE   = 8'h01;
    localparam logic [SUB_W-1:0] SUB_ACTIVE       = 8'h02;

    // Interface bits in the low half, protocol bits in the high half
    localparam int unsigned USB_IFACE_BIT                    = 0;
    localparam int unsigned RS485_IFACE_BIT                  = 1;
    localparam int unsigned RS232_IFACE_BIT                  = 2;
    localparam int unsigned CAN_IFACE_BIT                    = 3;
    localparam int unsigned ETHERNET_IFACE_BIT               = 4;
    localparam int unsigned REALTIME_INDUSTRIAL_ETHERNET_BIT = 5;
    localparam int unsigned SPI_IFACE_BIT                    = 6;
    localparam int unsigned SERIAL_MODBUS_PROTOCOL_BIT       = 16;
    localparam int unsigned NETWORKED_MODBUS_PROTOCOL_BIT    = 17;
    localparam int unsigned INDUSTRIAL_IP_PROTOCOL_BIT       = 18;

    localparam logic [DATA_W-1:0] IFACE_FIELD_MASK = 32'h0000_FFFF;
    localparam logic [DATA_W-1:0] PROTO_FIELD_MASK = 32'hFFFF_0000;
    localparam logic [DATA_W-1:0] ASSIGNED_MASK    = 32'h0007_007F;

    localparam logic [DATA_W-1:0] AVAILABILITY_RST = 32'h0000_0008;
    localparam logic [DATA_W-1:0] CONTROL_RST      = 32'h0000_0008;
    localparam logic [DATA_W-1:0] SWITCHABLE_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ACTIVE_RST       = 32'h0000_0008;
    localparam logic [SUB_W-1:0]  ENTRY_COUNT_RST  = 8'h02;

    typedef enum logic [2:0] {
        FBIS_SEL_NONE,
        FBIS_SEL_AVAIL,
        FBIS_SEL_CTRL,
        FBIS_SEL_COUNT,
        FBIS_SEL_SWITCH,
        FBIS_SEL_ACTIVE
    } fbis_sel_t;
endpackage
`default_nettype wire

// ---- verilog/fbis_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module fbis_top
    import fbis_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              obj_req,
    input  wire logic              obj_wr,
    input  wire logic [IDX_W-1:0]  obj_index,
    input  wire logic [SUB_W-1:0]  obj_subindex,
    input  wire logic [DATA_W-1:0] obj_wdata,
    output logic                   obj_ack,
    output logic                   obj_abort,
    output logic       [DATA_W-1:0] obj_rdata,
    input  wire logic [DATA_W-1:0] hw_available,
    input  wire logic [DATA_W-1:0] hw_switchable,
    input  wire logic              save_req,
    output logic                   nv_save_stb,
    output logic       [DATA_W-1:0] nv_save_data,
    input  wire logic              nv_restore_valid,
    input  wire logic [DATA_W-1:0] nv_restore_data,
    output logic       [DATA_W-1:0] bus_enable
);
    logic [DATA_W-1:0] avail_r;
    logic [DATA_W-1:0] switch_r;
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] ctrl_nxt;
    logic [DATA_W-1:0] active_r;
    logic [DATA_W-1:0] active_nxt;
    logic              restore_stb;
    logic [DATA_W-1:0] restore_value;
    fbis_sel_t         sel;
    logic              wr_ok;

    function automatic fbis_sel_t obj_decode(
        input logic [IDX_W-1:0] idx,
        input logic [SUB_W-1:0] sub
    );
        fbis_sel_t s;
        s = FBIS_SEL_NONE;
        if (idx == IDX_AVAILABILITY && sub == SUB_VALUE)
            s = FBIS_SEL_AVAIL;
        else if (idx == IDX_CONTROL && sub == SUB_VALUE)
            s = FBIS_SEL_CTRL;
        else if (idx == IDX_STATUS && sub == SUB_ENTRY_COUNT)
            s = FBIS_SEL_COUNT;
        else if (idx == IDX_STATUS && sub == SUB_SWITCHABLE)
            s = FBIS_SEL_SWITCH;
        else if (idx == IDX_STATUS && sub == SUB_ACTIVE)
            s = FBIS_SEL_ACTIVE;
        return s;
    endfunction

    // Keeps a word to its assigned interface and protocol positions
    function automatic logic [DATA_W-1:0] fold(input logic [DATA_W-1:0] v);
        return ((v & IFACE_FIELD_MASK) | (v & PROTO_FIELD_MASK))
               & ASSIGNED_MASK;
    endfunction

    assign sel   = obj_decode(obj_index, obj_subindex);
    assign wr_ok = obj_req && obj_wr && (sel == FBIS_SEL_CTRL);

    fbis_persist u_persist (
        .clk              (clk),
        .srst             (srst),
        .save_req         (save_req),
        .ctrl_value       (ctrl_r),
        .nv_restore_valid (nv_restore_valid),
        .nv_restore_data  (nv_restore_data),
        .nv_save_stb      (nv_save_stb),
        .nv_save_data     (nv_save_data),
        .restore_stb      (restore_stb),
        .restore_value    (restore_value)
    );

    // Build straps sampled every cycle; the unit may report late options
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            avail_r  <= AVAILABILITY_RST;
            switch_r <= SWITCHABLE_RST;
        end
        else
        begin
            avail_r  <= fold(hw_available);
            switch_r <= fold(hw_switchable) & fold(hw_available);
        end
    end

    // Non-switchable bits keep their value whatever software writes
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (restore_stb)
        begin
            ctrl_nxt = (ctrl_r & ~switch_r)
                       | (fold(restore_value) & switch_r);
        end
        if (wr_ok)
        begin
            ctrl_nxt = (ctrl_r & ~switch_r)
                       | (fold(obj_wdata) & switch_r);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_r <= CONTROL_RST;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // An available fixed bus always runs; a switchable one follows its control bit
    always_comb
    begin
        active_nxt = avail_r & ((ctrl_r & switch_r) | ~switch_r);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            active_r   <= ACTIVE_RST;
            bus_enable <= ACTIVE_RST;
        end
        else
        begin
            active_r   <= active_nxt & ASSIGNED_MASK;
            bus_enable <= active_nxt & ASSIGNED_MASK;
        end
    end

    // Object access answers one cycle after the request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            obj_ack   <= 1'b0;
            obj_abort <= 1'b0;
            obj_rdata <= '0;
        end
        else
        begin
            obj_ack   <= obj_req;
            obj_abort <= 1'b0;
            if (obj_req)
            begin
                obj_rdata <= '0;
                if (obj_wr)
                begin
                    obj_abort <= !wr_ok;
                end
                else
                begin
                    case (sel)
                        FBIS_SEL_AVAIL:  obj_rdata <= avail_r;
                        FBIS_SEL_CTRL:   obj_rdata <= ctrl_r;
                        FBIS_SEL_COUNT:
                            obj_rdata <= {{(DATA_W-SUB_W){1'b0}},
                                          ENTRY_COUNT_RST};
                        FBIS_SEL_SWITCH: obj_rdata <= switch_r;
                        FBIS_SEL_ACTIVE: obj_rdata <= active_r;
                        default:         obj_abort <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire
